// ==== src/rds_top.sv ====
// Our own choices: strobed register access and the address map.
`default_nettype none
// Functional notes
// - release reset after power-on and start-up delays
// - oscillator and lock waits run alongside reset
// - power-on adds power-on delay; brown-out omits
// - start-up is regulator or power-up timer delay
// - other resets hold only internal reset time
// - start-up counter: ten bits, 1024 periods
// - added clock wait depends on clock source
// - no execution before valid clock released
// - monitor after release; fail switches to fast rc
// - crystal or pll sources add monitor delay
// - only special registers depend on reset type
// - oscillator reset value from new oscillator select; other resets with switching on take current oscillator
// - calibration and nvm registers reset by power-on only
// - any active source asserts system reset
// - power-on clears flags, sets brown-out and power-on
// - switching disabled uses configured oscillator always
module rds_top
   import rds_pkg::*;
#(
   parameter int POWER_UP_TIMER_CYCLES = rds_pkg::POWER_UP_TIMER_CYC    // shortenable power-up timer
) (
   // clocking (internal always-running timebase)
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   // reset sources from pins and other clocks
   input  wire logic        power_on_in,
   input  wire logic        brown_out_in,
   input  wire logic        master_clear_pin_n,
   input  wire logic        watchdog_in,
   input  wire logic        soft_reset_in,
   input  wire logic        illegal_op_in,
   input  wire logic        uninit_w_in,
   input  wire logic        trap_conflict_in,
   input  wire logic        config_mismatch_in,
   // oscillator side
   input  wire logic        osc_tick_in,
   input  wire logic        pll_locked_in,
   input  wire logic        clock_valid_in,
   // configuration
   input  wire logic [2:0]  new_oscillator_select,
   input  wire logic        clock_switch_en,
   input  wire logic [2:0]  current_osc_in,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // results
   output logic             system_reset_out,
   output logic             exec_enable,
   output logic             clock_release,
   output logic             monitor_active,
   output logic             osc_fail_trap,
   output logic             select_fast_rc,
   output logic             irq
);
   import rds_pkg::*;

   // -------------------------------------------------------------
   // synchronised pins
   // -------------------------------------------------------------
   logic [11:0] pin_raw;
   logic [11:0] pin_s;
   assign pin_raw = {power_on_in, brown_out_in, ~master_clear_pin_n, watchdog_in,
                     soft_reset_in, illegal_op_in, uninit_w_in, trap_conflict_in,
                     config_mismatch_in, osc_tick_in, pll_locked_in, clock_valid_in};
   rds_sync #(.WIDTH(12)) u_sync (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .d     (pin_raw),
      .q     (pin_s)
   );
   logic por_s, bor_s, ext_s, wdt_s, swr_s, iop_s, uw_s, trp_s, cm_s;
   logic tick_s, lock_s, valid_s;
   assign {por_s, bor_s, ext_s, wdt_s, swr_s, iop_s, uw_s, trp_s,
           cm_s, tick_s, lock_s, valid_s} = pin_s;
   logic any_src;
   assign any_src = por_s | bor_s | ext_s | wdt_s | swr_s | iop_s | uw_s | trp_s | cm_s;

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   logic [15:0] status_q;         // reset flags
   logic [15:0] config_q;         // [2:0] clock source, [3] regulator on, [4] monitor en
   logic [15:0] osc_q;            // [14:12] current oscillator
   logic [15:0] rtccal_q;         // calibration, power-on reset only
   logic [15:0] nvm_q;            // nvm control, power-on reset only
   logic [3:0]  irq_stat_q;       // sticky events
   logic [3:0]  irq_en_q;         // event enables
   logic        por_seen_q;       // last reset was power-on class
   logic        bor_seen_q;       // last reset was brown-out
   rds_clk_src_type src;
   logic        reg_on;
   logic        mon_en;
   assign src    = rds_clk_src_type'(config_q[2:0]);
   assign reg_on = config_q[3];
   assign mon_en = config_q[4];

   // -------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      SQ_HOLD, SQ_POWER_ON, SQ_STARTUP, SQ_INTERNAL, SQ_MONITOR_WAIT, SQ_RUN
   } rds_seq_type;
   rds_seq_type     seq_q;
   logic [CNT_W-1:0] cnt_q;
   logic [OST_WIDTH-1:0] ost_q;   // oscillator start-up counter
   logic            ost_done_q;
   logic            tick_d1_q;
   logic            need_ost, need_lock, need_mon;
   logic            clk_ok;
   logic            osc_released;

   assign need_ost  = por_seen_q && (src == CS_XTAL || src == CS_XTALPLL);
   assign need_lock = por_seen_q && (src == CS_PLL || src == CS_XTALPLL);
   assign need_mon  = src == CS_PLL || src == CS_XTAL || src == CS_XTALPLL;
   assign clk_ok    = (!need_ost || ost_done_q) && (!need_lock || lock_s);
   assign osc_released = clk_ok;

   // sequencer counts on the internal timebase, not the oscillator
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         seq_q <= SQ_HOLD;
         cnt_q <= '0;
      end
      else if (ce)
      begin
         if (any_src)
         begin
            seq_q <= SQ_HOLD;
            cnt_q <= '0;
         end
         else
         begin
            unique case (seq_q)
               SQ_HOLD:
               begin
                  cnt_q <= '0;
                  if (por_seen_q && !bor_seen_q)
                     seq_q <= SQ_POWER_ON;
                  else if (por_seen_q)
                     seq_q <= SQ_STARTUP;                        // brown-out skips
                  else
                     seq_q <= SQ_INTERNAL;
               end
               SQ_POWER_ON:
                  if (cnt_q >= CNT_W'(POR_CYC - 1))
                  begin
                     seq_q <= SQ_STARTUP;
                     cnt_q <= '0;
                  end
                  else
                     cnt_q <= cnt_q + 1'b1;
               SQ_STARTUP:
                  // regulator settle or power-up timer
                  if (cnt_q >= (reg_on ? CNT_W'(VREG_CYC - 1) : CNT_W'(POWER_UP_TIMER_CYCLES - 1)))
                  begin
                     seq_q <= SQ_INTERNAL;
                     cnt_q <= '0;
                  end
                  else
                     cnt_q <= cnt_q + 1'b1;
               SQ_INTERNAL:
                  if (cnt_q >= CNT_W'(RST_CYC - 1))
                  begin
                     seq_q <= (por_seen_q && need_mon) ? SQ_MONITOR_WAIT : SQ_RUN;
                     cnt_q <= '0;
                  end
                  else
                     cnt_q <= cnt_q + 1'b1;
               SQ_MONITOR_WAIT:
                  if (cnt_q >= CNT_W'(MON_CYC - 1))
                  begin
                     seq_q <= SQ_RUN;
                     cnt_q <= '0;
                  end
                  else
                     cnt_q <= cnt_q + 1'b1;
               SQ_RUN:
                  cnt_q <= '0;
            endcase
         end
      end
   end

   // oscillator start-up counter runs in parallel with the reset delay
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ost_q      <= '0;
         ost_done_q <= 1'b0;
         tick_d1_q  <= 1'b0;
      end
      else if (ce)
      begin
         tick_d1_q <= tick_s;
         if (por_s || bor_s)
         begin
            ost_q      <= '0;
            ost_done_q <= 1'b0;
         end
         else if (tick_s && !tick_d1_q && !ost_done_q)
         begin
            ost_q <= ost_q + 1'b1;
            if (ost_q == OST_WIDTH'(OST_PERIODS - 1))
               ost_done_q <= 1'b1;                               // 1024th period
         end
      end
   end

   // reset class capture: brown-out also marks power-on class
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         por_seen_q <= 1'b1;
         bor_seen_q <= 1'b0;
      end
      else if (ce)
      begin
         if (por_s)
         begin
            por_seen_q <= 1'b1;
            bor_seen_q <= 1'b0;
         end
         else if (bor_s)
         begin
            por_seen_q <= 1'b1;
            bor_seen_q <= 1'b1;
         end
         else if (any_src)
         begin
            por_seen_q <= 1'b0;
            bor_seen_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         system_reset_out <= 1'b1;
         exec_enable      <= 1'b0;
         clock_release    <= 1'b0;
         monitor_active   <= 1'b0;
         osc_fail_trap    <= 1'b0;
         select_fast_rc   <= 1'b0;
      end
      else if (ce)
      begin
         // released only once power-on, start-up and internal delays end
         system_reset_out <= any_src || seq_q == SQ_HOLD || seq_q == SQ_POWER_ON
                             || seq_q == SQ_STARTUP || seq_q == SQ_INTERNAL;
         clock_release    <= osc_released;
         exec_enable      <= !any_src && (seq_q == SQ_MONITOR_WAIT || seq_q == SQ_RUN)
                             && osc_released;
         monitor_active   <= !any_src && mon_en && seq_q == SQ_RUN;
         if (any_src)
         begin
            osc_fail_trap  <= 1'b0;
            select_fast_rc <= 1'b0;
         end
         else if (mon_en && seq_q == SQ_RUN && !valid_s)
         begin
            osc_fail_trap  <= 1'b1;
            select_fast_rc <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // status flags: hardware set wins over software write
   // -------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
         status_q <= STATUS_POR_VAL;
      else if (ce)
      begin
         if (por_s)
            status_q <= STATUS_POR_VAL;
         else
         begin
            if (reg_wr && reg_addr == REG_STATUS)
               status_q <= reg_wdata & STATUS_IMPL;
            if (bor_s)
               status_q[F_BOR] <= 1'b1;
            if (ext_s)
               status_q[F_EXT] <= 1'b1;
            if (wdt_s)
               status_q[F_WDT] <= 1'b1;
            if (swr_s)
               status_q[F_SWR] <= 1'b1;
            if (cm_s)
               status_q[F_CM] <= 1'b1;
            if (iop_s || uw_s)
               status_q[F_IOP] <= 1'b1;
            if (trp_s)
               status_q[F_TRP] <= 1'b1;
         end
      end
   end

   // config: ordinary reset value for every reset type
   always_ff @(posedge clock)
   begin
      if (rst)
         config_q <= CONFIG_RST;
      else if (ce)
      begin
         if (any_src)
            config_q <= CONFIG_RST;
         else if (reg_wr && reg_addr == REG_CONFIG)
            config_q <= reg_wdata;
      end
   end

   // oscillator control: reset value from select bits and reset type
   always_ff @(posedge clock)
   begin
      if (rst)
         osc_q <= {1'b0, new_oscillator_select, 12'h000};
      else if (ce)
      begin
         if (por_s || bor_s || !clock_switch_en)
            osc_q <= {1'b0, new_oscillator_select, 12'h000};
         else if (any_src)
            osc_q <= {1'b0, current_osc_in, 12'h000};
         else if (select_fast_rc)
            osc_q[14:12] <= FAST_RC_CODE;
         else if (reg_wr && reg_addr == REG_OSC)
            osc_q <= reg_wdata;
      end
   end

   // calibration and nvm control survive all but power-on
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rtccal_q <= RTCCAL_RST;
         nvm_q    <= NVM_RST;
      end
      else if (ce)
      begin
         if (por_s)
         begin
            rtccal_q <= RTCCAL_RST;
            nvm_q    <= NVM_RST;
         end
         else if (reg_wr && reg_addr == REG_RTCCAL)
            rtccal_q <= reg_wdata;
         else if (reg_wr && reg_addr == REG_NVM)
            nvm_q <= reg_wdata;
      end
   end

   // -------------------------------------------------------------
   // interrupts: 0 reset released, 1 clock released, 2 clock fail, 3 reset seen
   // -------------------------------------------------------------
   logic [3:0] ev;
   // clock fail taken from the trap's own set condition, as trap and fast rc rise together
   assign ev = {any_src,
                ~any_src & mon_en & (seq_q == SQ_RUN) & ~valid_s & ~osc_fail_trap,
                osc_released & ~clock_release,
                system_reset_out & ~any_src
                & (seq_q == SQ_RUN || seq_q == SQ_MONITOR_WAIT)};
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         irq_stat_q <= 4'h0;
         irq_en_q   <= 4'h0;
         irq        <= 1'b0;
      end
      else if (ce)
      begin
         // set beats clear in the same cycle
         irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == REG_IRQ_CLR) ?
                        reg_wdata[3:0] : 4'h0)) | ev;
         if (reg_wr && reg_addr == REG_IRQ_EN)
            irq_en_q <= reg_wdata[3:0];
         irq <= |(irq_stat_q & irq_en_q);
      end
   end

   // -------------------------------------------------------------
   // read port, data one cycle after strobe
   // -------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (ce)
      begin
         if (reg_rd)
         begin
            unique case (reg_addr)
               REG_STATUS:   reg_rdata <= status_q;
               REG_CONFIG:   reg_rdata <= config_q;
               REG_OSC:      reg_rdata <= osc_q;
               REG_RTCCAL:   reg_rdata <= rtccal_q;
               REG_NVM:      reg_rdata <= nvm_q;
               REG_IRQ_STAT: reg_rdata <= {12'h000, irq_stat_q};
               REG_IRQ_EN:   reg_rdata <= {12'h000, irq_en_q};
               REG_SEQ:      reg_rdata <= {5'h00, ost_done_q, 7'h00, 3'(seq_q)};
               default:      reg_rdata <= 16'h0000;               // unmapped, write-only
            endcase
         end
         else
            reg_rdata <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

// ==== src/rds_pkg.sv ====
`default_nettype none
package rds_pkg;
   // ---------------------------------------------------------------
   // timing (clock is 10 MHz)
   // ---------------------------------------------------------------
   localparam int CLOCK_HZ            = 10_000_000;
   localparam int POWER_ON_DELAY_NS   = 10_000;     // nominal power-on delay
   localparam int REG_SETTLE_NS       = 10_000;     // regulator settle delay
   localparam int POWER_UP_TIMER_MS             = 64;         // power-up timer delay
   localparam int INT_RESET_NS        = 32_000;     // internal state reset time
   localparam int MONITOR_DELAY_NS    = 100_000;    // clock monitor delay
   localparam int POR_CYC    = (POWER_ON_DELAY_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int VREG_CYC   = (REG_SETTLE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int POWER_UP_TIMER_CYC   = POWER_UP_TIMER_MS * (CLOCK_HZ / 1000);
   localparam int RST_CYC    = (INT_RESET_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int MON_CYC    = (MONITOR_DELAY_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int OST_PERIODS = 1024;               // oscillator periods counted
   localparam int OST_WIDTH   = 10;                 // start-up counter width
   localparam int CNT_W       = 20;                 // delay counter width
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_STATUS   = 4'h0;      // reset flags, read/write
   localparam logic [3:0] REG_CONFIG   = 4'h1;      // clock and option config
   localparam logic [3:0] REG_OSC      = 4'h2;      // oscillator control
   localparam logic [3:0] REG_RTCCAL   = 4'h3;      // rtc calibration
   localparam logic [3:0] REG_NVM      = 4'h4;      // nvm control
   localparam logic [3:0] REG_IRQ_STAT = 4'h5;      // sticky events
   localparam logic [3:0] REG_IRQ_EN   = 4'h6;      // event enables
   localparam logic [3:0] REG_IRQ_CLR  = 4'h7;      // write-one-to-clear
   localparam logic [3:0] REG_SEQ      = 4'h8;      // sequencer state
   // status flag positions
   localparam int F_POR = 0;
   localparam int F_BOR = 1;
   localparam int F_EXT = 7;
   localparam int F_SWR = 6;
   localparam int F_WDT = 4;
   localparam int F_CM  = 9;
   localparam int F_IOP = 14;
   localparam int F_TRP = 15;
   localparam logic [15:0] STATUS_POR_VAL = 16'h0003;
   localparam logic [15:0] STATUS_IMPL    = 16'hC3FF;
   localparam logic [15:0] CONFIG_RST     = 16'h0000;
   localparam logic [15:0] RTCCAL_RST     = 16'h0000;
   localparam logic [15:0] NVM_RST        = 16'h0000;
   // clock source codes held in the config register (low three bits)
   typedef enum logic [2:0] {
      CS_EC, CS_FRC, CS_FRCDIV, CS_LOW_POWER_INTERNAL_RC, CS_PLL, CS_XTAL, CS_XTALPLL
   } rds_clk_src_type;
   localparam logic [2:0] FAST_RC_CODE = 3'h1;
endpackage
`default_nettype wire

// ==== src/rds_sync.sv ====
`default_nettype none
// two-flop synchroniser for a vector of pin levels
module rds_sync #(
   parameter int WIDTH = 1
) (
   // clocking
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             ce,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;                // first stage, read only by q
   // -------------------------------------------------------------
   // two stages
   // -------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else if (ce)
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== sim/rds_top_assertions.sv ====
`default_nettype none
module rds_top_assertions
   import rds_pkg::*;
#(
   parameter int POWER_UP_TIMER_CYCLES = 50   // shortened power-up timer
) (
   // clocking
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        ce,
   // reset sources
   input wire logic        power_on_in,
   input wire logic        brown_out_in,
   input wire logic        master_clear_pin_n,
   input wire logic        watchdog_in,
   input wire logic        soft_reset_in,
   input wire logic        illegal_op_in,
   input wire logic        uninit_w_in,
   input wire logic        trap_conflict_in,
   input wire logic        config_mismatch_in,
   // oscillator and configuration
   input wire logic        osc_tick_in,
   input wire logic        pll_locked_in,
   input wire logic        clock_valid_in,
   input wire logic [2:0]  new_oscillator_select,
   input wire logic        clock_switch_en,
   input wire logic [2:0]  current_osc_in,
   // register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // results
   input wire logic        system_reset_out,
   input wire logic        exec_enable,
   input wire logic        clock_release,
   input wire logic        monitor_active,
   input wire logic        osc_fail_trap,
   input wire logic        select_fast_rc,
   input wire logic        irq
);
   // ---------------------------------------------------------------
   // helper logic
   // ---------------------------------------------------------------
   logic        any_src;    // some reset source is active
   logic [19:0] hi_cnt_q;   // cycles the system reset has stood high
   assign any_src = power_on_in | brown_out_in | !master_clear_pin_n | watchdog_in
                  | soft_reset_in | illegal_op_in | uninit_w_in | trap_conflict_in
                  | config_mismatch_in;
   // saturating count, so a long power-up hold cannot wrap to a small value
   always_ff @(posedge clock)
   begin
      if (rst || !system_reset_out)
         hi_cnt_q <= 20'h0_0000;
      else if (hi_cnt_q != 20'hF_FFFF)
         hi_cnt_q <= hi_cnt_q + 20'h0_0001;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence src_held;   // source seen long enough to pass the synchroniser
      any_src [*3];
   endsequence
   sequence released;   // system reset drops
      $fell(system_reset_out);
   endsequence
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_hold_after_init: assert property (
      $fell(rst) |-> system_reset_out [*8]) else $error("reset dropped right after init");
   a_source_asserts: assert property (
      src_held |-> ##[0:2] system_reset_out) else $error("active source without reset");
   a_internal_time: assert property (
      released |-> hi_cnt_q >= 20'h0_0140) else $error("reset held too short");
   a_exec_gated: assert property (
      $rose(exec_enable) |-> clock_release && !system_reset_out) else $error("early exec");
   a_monitor_after: assert property (
      $rose(monitor_active) |-> !system_reset_out) else $error("monitor during reset");
   a_trap_fast_rc: assert property (
      $rose(osc_fail_trap) |-> ##[0:2] select_fast_rc) else $error("no fast rc on fail");
   a_trap_monitored: assert property (
      $rose(osc_fail_trap) |-> monitor_active) else $error("trap without monitor");
   a_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == 16'h0000) else $error("read data without read");
endmodule
bind rds_top rds_top_assertions #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) rds_top_assertions_i (.*);
`default_nettype wire

// ==== sim/rds_top_tb_top.sv ====
`default_nettype none
module rds_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import rds_pkg::*;
   // ---------------------------------------------------------------
   // signals and case table
   // ---------------------------------------------------------------
   logic        clock = 1'b0, rst = 1'b1, ce = 1'b1, pll_locked_in = 1'b1;
   logic        clock_valid_in = 1'b1, clock_switch_en = 1'b0, osc_tick_in = 1'b0;
   logic [2:0]  new_oscillator_select = 3'h5, current_osc_in = 3'h0;
   logic [8:0]  src_q = 9'h000;   // one bit per source, high = active
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_val;
   logic        reg_wr = 1'b0, reg_rd = 1'b0;
   logic        power_on_in, brown_out_in, master_clear_pin_n, watchdog_in;
   logic        soft_reset_in, illegal_op_in, uninit_w_in, trap_conflict_in;
   logic        config_mismatch_in, system_reset_out, exec_enable, clock_release;
   logic        monitor_active, osc_fail_trap, select_fast_rc, irq;
   int          n_errors = 0, cmp_count = 0, cyc = 0, n;
   // rows: release-to-drop floor, status expected, clock source
   int          r_lo [9] = '{470, 370, 320, 320, 320, 320, 320, 320, 320};
   logic [15:0] r_flag [9] = '{16'h0003, 16'h0102, 16'h0180, 16'h0110, 16'h0140,
                               16'h4100, 16'h4100, 16'h8100, 16'h0300};
   logic [2:0]  r_src [9] = '{3'h6, 3'h5, 3'h0, 3'h4, 3'h5, 3'h1, 3'h6, 3'h3, 3'h2};
   assign {power_on_in, brown_out_in} = {src_q[0], src_q[1]};
   assign master_clear_pin_n = !src_q[2];
   assign {watchdog_in, soft_reset_in, illegal_op_in} = {src_q[3], src_q[4], src_q[5]};
   assign {uninit_w_in, trap_conflict_in, config_mismatch_in} = {src_q[6], src_q[7], src_q[8]};
   rds_top #(.POWER_UP_TIMER_CYCLES(50)) rds_top_i (.*);
   always #50 clock = ~clock;
   // oscillator runs free at half the timebase rate
   always @(posedge clock) osc_tick_in <= ~osc_tick_in;
   // hang guard
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_errors++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      rd_val = reg_rdata;
   endtask
   // counts settled cycles until the system reset drops, capped
   task automatic wait_drop(input int start);
      n = start;
      while (system_reset_out !== 1'b0 && n < 600)
      begin
         @(negedge clock);
         n++;
      end
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      wait_drop(0);
      chk(20'(n >= 466 && n <= 484), 20'h0_0001);
      for (int i = 0; i < 9; i++)
      begin
         wr(REG_RTCCAL, 16'h1234);
         wr(REG_STATUS, 16'h0100);
         @(posedge clock);
         src_q[i] <= 1'b1;
         repeat (4) @(posedge clock);
         src_q[i] <= 1'b0;
         // config is cleared while a source is seen, so write it once the source has left
         repeat (2) @(posedge clock);
         wr(REG_CONFIG, {12'h001, 1'b0, r_src[i]});
         wait_drop(2);
         chk(20'(n >= r_lo[i] - 4 && n <= r_lo[i] + 12), 20'h0_0001);
         n = 0;
         while (monitor_active !== 1'b1 && n < 1200)
         begin
            @(negedge clock);
            n++;
         end
         if (i < 2 || r_src[i] < 3'h4)
            chk(20'(n >= 990), 20'(r_src[i] >= 3'h4));
         // crystal start-up still counting after a power-class reset holds execution
         chk(20'(exec_enable), 20'(i >= 2 || r_src[i] < 3'h5));
         rd(REG_STATUS);
         chk(20'(rd_val), 20'(r_flag[i]));
         rd(REG_RTCCAL);
         chk(20'(rd_val), (i == 0) ? 20'h0_0000 : 20'h0_1234);
      end
      // switching disabled: oscillator field follows the configured select
      rd(REG_OSC);
      chk(20'(rd_val[14:12]), 20'h0_0005);
      // lost clock while monitored
      @(posedge clock);
      clock_valid_in <= 1'b0;
      n = 0;
      while (osc_fail_trap !== 1'b1 && n < 50)
      begin
         @(negedge clock);
         n++;
      end
      chk(20'({osc_fail_trap, select_fast_rc}), 20'h0_0003);
      @(posedge clock);
      clock_valid_in <= 1'b1;
      // interrupt: masked, enabled on a sticky event, cleared
      wr(REG_IRQ_EN, 16'h0000);
      repeat (2) @(negedge clock);
      chk(20'(irq), 20'h0_0000);
      wr(REG_IRQ_EN, 16'h0001);
      repeat (2) @(negedge clock);
      chk(20'(irq), 20'h0_0001);
      wr(REG_IRQ_CLR, 16'h0001);
      repeat (2) @(negedge clock);
      chk(20'(irq), 20'h0_0000);
      rd(REG_IRQ_STAT);
      chk(20'(rd_val), 20'h0_000E);
      rd(4'hF);
      chk(20'(rd_val), 20'h0_0000);
      // switching enabled: a watchdog reset keeps the current oscillator
      @(posedge clock);
      clock_switch_en <= 1'b1;
      current_osc_in  <= 3'h2;
      src_q[3]        <= 1'b1;
      repeat (4) @(posedge clock);
      src_q[3] <= 1'b0;
      rd(REG_OSC);
      chk(20'(rd_val[14:12]), 20'h0_0002);
      summarize();
   end
endmodule
`default_nettype wire
